// *** hw/bmeu_exec_unit.sv ***
// Execution unit for the single-bit complement, clear, set and OR instructions.
//
// Functional notes
// RULE_01 - Complement inverts only the chosen bit; other seven bits are kept.
// RULE_02 - After complement: Z from result, S cleared, V undefined, C D H kept.
// RULE_03 - Clear forces the chosen bit to zero, other bits kept.
// RULE_04 - Clear and set leave all six flags untouched.
// RULE_05 - Set forces the chosen bit to one, other bits kept.
// RULE_06 - Opcode 77 selects clear when selector is 0, set when 1.
// RULE_07 - Second byte: 4-bit address, 3-bit bit index, 1-bit selector.
// RULE_08 - Opcode 57 complements, 77 clears or sets, 07 ORs.
// RULE_09 - Two-byte instructions take 4 cycles, the three-byte OR takes 6.
// RULE_10 - OR writes only the destination bit; source and other bits kept.
// RULE_11 - Selector 0: working bit 0 gets full bit b; 1: the reverse.
// RULE_12 - After OR: Z from result, S cleared, V undefined, C D H kept.
// RULE_13 - Read, modify and write back run without interleaved accesses.
`timescale 1ns/10ps
module bmeu_exec_unit (
  input  wire logic                  core_clk,     // Core clock
  input  wire logic                  resetn,       // Synchronous reset, active low
  input  wire logic                  issueValid,   // Decode offers an instruction
  input  wire bmeu_pkg::bmeuInstr_t  issueInstr,   // Opcode and operand bytes
  output logic                       issueReady,   // Unit idle, a legal offer is taken
  output logic                       opDone,       // Last cycle of an instruction
  output logic                       illegalOp,    // Offer was not a bit instruction
  input  wire logic [7:0]            workPtr,      // Working register bank pointer
  output bmeu_pkg::bmeuRegReq_t      regReq,       // Register file request
  input  wire logic [7:0]            regRdata,     // Read data, one cycle after rd
  output logic                       regLock,      // Register file held by the unit
  input  wire logic                  flagLoad,     // Core writes the condition register
  input  wire logic [7:0]            flagLoadData, // Value the core writes
  output bmeu_pkg::bmeuFlags_t       flags,        // Current condition flags
  output logic [7:0]                 flagsByte     // Condition register as a byte
);
  import bmeu_pkg::*;

  // The sequencer realises the cycle counts; refuse a package that disagrees.
  if (CYC_SHORT != PATH_SHORT || CYC_LONG != PATH_LONG) begin : gCycleCheck
    $error("Instruction cycle counts do not match the sequencer path.");
  end

  // The decode below assumes the three fields tile the second byte from bit 7 down.
  if (ADDR_FIELD_MSB != 7 || ADDR_FIELD_LSB != BIT_FIELD_MSB + 1 || SEL_FIELD_POS != 0 ||
      BIT_FIELD_MSB - BIT_FIELD_LSB != 2 || BIT_FIELD_LSB != SEL_FIELD_POS + 1) begin : gFieldCheck
    $error("Second byte field layout does not match the decode widths.");
  end

  bmeuState_t  state;
  bmeuState_t  next_state;
  bmeuOp_t     curOp;
  logic [2:0]  curBit;
  logic        curSel;
  logic [7:0]  workAddr;
  logic [7:0]  fullAddr;
  logic        srcBit;
  logic [7:0]  resultByte;
  logic        resultZero;
  bmeuRegReq_t next_regReq;
  logic        doneReg;
  logic        illegalReg;

  // Instruction field decode.
  wire logic [7:0] opcode;
  wire logic [3:0] addrField;
  wire logic [2:0] bitField;
  wire logic       selField;
  wire logic       isComplement;
  wire logic       isClearSet;
  wire logic       isOr;
  wire logic       isLegal;
  wire logic       accept;
  wire bmeuOp_t    decOp;

  assign opcode    = issueInstr.opcode;
  assign addrField = issueInstr.byte2[ADDR_FIELD_MSB:ADDR_FIELD_LSB]; // RULE_07
  assign bitField  = issueInstr.byte2[BIT_FIELD_MSB:BIT_FIELD_LSB];   // RULE_07
  assign selField  = issueInstr.byte2[SEL_FIELD_POS];                 // RULE_07

  // The complement exists only in its selector-0 form.
  assign isComplement = (opcode == OPC_BIT_COMPLEMENT) && !selField; // RULE_08
  assign isClearSet   = (opcode == OPC_BIT_CLEAR_SET);               // RULE_08
  assign isOr         = (opcode == OPC_BIT_OR);                      // RULE_08
  assign isLegal      = isComplement | isClearSet | isOr;

  assign decOp = isOr         ? OP_OR :
                 isComplement ? OP_COMPLEMENT :
                 selField     ? OP_SET : OP_CLEAR; // RULE_06

  // State decodes shared by the request, capture and flag logic.
  wire logic inIdle;
  wire logic inRdDst;
  wire logic inCalc;
  wire logic inWrite;

  assign inIdle  = (state == ST_IDLE);
  assign inRdDst = (state == ST_RD_DST);
  assign inCalc  = (state == ST_CALC);
  assign inWrite = (state == ST_WRITE);

  assign issueReady = inIdle;
  assign accept     = issueReady && issueValid && isLegal;

  // Operand addressing for the held instruction.
  wire logic       orForm1;
  wire logic [7:0] dstAddr;
  wire logic [2:0] tgtIdx;
  wire logic       srcSample;
  wire logic [7:0] offerWorkAddr;
  wire logic [7:0] offerFirstAddr;
  wire logic [7:0] reqAddr;

  assign orForm1 = (curOp == OP_OR) && curSel;

  // Selector 0 writes bit 0 of the working register from bit b of the full one.
  assign dstAddr = orForm1 ? fullAddr : workAddr;                  // RULE_11
  // The first read leaves in the accept cycle, before the held fields load, so
  // its address is built from the offered bytes: the source for an OR, else the
  // destination. Every later request uses the held destination.
  assign offerWorkAddr  = {workPtr[7:4], addrField};                              // RULE_07
  assign offerFirstAddr = (isOr && !selField) ? issueInstr.byte3 : offerWorkAddr; // RULE_11
  assign reqAddr        = inIdle ? offerFirstAddr : dstAddr;
  assign tgtIdx  = (curOp == OP_OR && !curSel) ? 3'h0 : curBit;    // RULE_11
  assign srcSample = orForm1 ? regRdata[0] : regRdata[curBit];     // RULE_11

  // Modify stage works on the destination byte as it returns.
  wire logic [7:0] aluResult;
  wire logic       aluZero;

  bmeu_bit_alu uAlu (
    .op         (curOp),
    .dstByte    (regRdata),
    .srcBit     (srcBit),
    .tgtIdx     (tgtIdx),
    .result     (aluResult),
    .resultZero (aluZero)
  );

  // Sequencer: three-byte OR spends two more cycles on the source read
  // and a hold stage, keeping the instruction lengths at 4 and 6 cycles.
  // States are Gray coded along the OR path from idle to write, so each of those steps flips one state bit.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = isOr ? ST_RD_SRC : ST_RD_DST; // RULE_09
        end
      end
      ST_RD_SRC: begin
        next_state = ST_RD_DST;
      end
      ST_RD_DST: begin
        next_state = ST_CALC;
      end
      ST_CALC: begin
        next_state = (curOp == OP_OR) ? ST_HOLD : ST_WRITE; // RULE_09
      end
      ST_HOLD: begin
        next_state = ST_WRITE;
      end
      ST_WRITE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Held instruction fields, captured on accept. Decode may move on to its next
  // offer at once, since nothing reads the offered bytes after the accept edge.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      curOp    <= OP_COMPLEMENT;
      curBit   <= 3'h0;
      curSel   <= 1'b0;
      workAddr <= 8'h00;
      fullAddr <= 8'h00;
    end else if (accept) begin
      curOp    <= decOp;
      curBit   <= bitField;
      curSel   <= selField;
      workAddr <= offerWorkAddr;
      fullAddr <= issueInstr.byte3;
    end
  end

  // Source bit arrives in the cycle after the source read.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      srcBit <= 1'b0;
    end else if (inRdDst && curOp == OP_OR) begin
      srcBit <= srcSample; // RULE_10
    end
  end

  // Result is held so the OR can wait one stage before its write.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      resultByte <= 8'h00;
      resultZero <= 1'b0;
    end else if (inCalc) begin
      resultByte <= aluResult;
      resultZero <= aluZero;
    end
  end

  // Register requests are registered and follow the next state, so every
  // strobe lines up with the state that owns it. Address and data fall back
  // to zero in idle, which keeps the bus quiet between instructions.
  always_comb begin
    next_regReq       = '0;
    next_regReq.rd    = (next_state == ST_RD_SRC) || (next_state == ST_RD_DST);
    next_regReq.wr    = (next_state == ST_WRITE); // RULE_13
    next_regReq.addr  = reqAddr;
    next_regReq.wdata = inCalc ? aluResult : resultByte;
    if (next_state == ST_IDLE) begin
      next_regReq.addr  = 8'h00;
      next_regReq.wdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      regReq <= '0;
    end else begin
      regReq <= next_regReq;
    end
  end

  // The register file stays held from the first read to the write-back.
  // Other masters must give way while this is high.
  assign regLock = !inIdle; // RULE_13

  // Completion and refusal pulses, one cycle each. A refused offer leaves the
  // unit idle, so decode may retry in the very next cycle.
  wire logic next_done;
  wire logic next_illegal;

  assign next_done    = (next_state == ST_WRITE);             // RULE_09
  assign next_illegal = issueReady && issueValid && !isLegal; // RULE_08

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      doneReg    <= 1'b0;
      illegalReg <= 1'b0;
    end else begin
      doneReg    <= next_done;
      illegalReg <= next_illegal;
    end
  end

  assign opDone    = doneReg;
  assign illegalOp = illegalReg;

  // Condition flags.
  wire logic       flagUpdate;
  wire logic       flagsWritten;
  wire logic [7:0] flagSource;
  wire logic       flagsLoadNow;
  wire bmeuFlags_t loadedFlags;
  wire bmeuFlags_t updatedFlags;
  wire bmeuFlags_t next_flags;

  // Overflow is undefined after these operations; it is simply kept.
  assign flagUpdate = inWrite &&
                      ((curOp == OP_COMPLEMENT) || (curOp == OP_OR)); // RULE_02 RULE_04 RULE_12
  // A write-back that targets the condition register replaces the flags.
  assign flagsWritten = regReq.wr && (regReq.addr == FLAGS_ADDR);
  assign flagSource   = flagsWritten ? regReq.wdata : flagLoadData;
  // A load from the core is refused while busy, so it cannot race the update.
  assign flagsLoadNow = flagsWritten || (flagLoad && inIdle);
  assign loadedFlags  = {flagSource[FLAG_C_POS], flagSource[FLAG_Z_POS], flagSource[FLAG_S_POS],
                         flagSource[FLAG_V_POS], flagSource[FLAG_D_POS], flagSource[FLAG_H_POS]};
  assign updatedFlags = {flags.c, resultZero, 1'b0, flags.v, flags.d, flags.h}; // RULE_02 RULE_12
  // A load wins over the update, as a write-back to the flags must stick.
  assign next_flags   = flagsLoadNow ? loadedFlags :
                        flagUpdate   ? updatedFlags : flags; // RULE_04

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flags.c <= FLAGS_RESET[FLAG_C_POS];
      flags.z <= FLAGS_RESET[FLAG_Z_POS];
      flags.s <= FLAGS_RESET[FLAG_S_POS];
      flags.v <= FLAGS_RESET[FLAG_V_POS];
      flags.d <= FLAGS_RESET[FLAG_D_POS];
      flags.h <= FLAGS_RESET[FLAG_H_POS];
    end else begin
      flags <= next_flags;
    end
  end

  assign flagsByte = {flags.c, flags.z, flags.s, flags.v, flags.d, flags.h, 2'b00};

endmodule

// *** pkg/bmeu_pkg.sv ***
// Shared constants, types and encodings of the bit manipulation execution unit.
package bmeu_pkg;

  // Opcodes recognised by the unit.
  localparam logic [7:0] OPC_BIT_COMPLEMENT = 8'h57;
  localparam logic [7:0] OPC_BIT_CLEAR_SET  = 8'h77;
  localparam logic [7:0] OPC_BIT_OR         = 8'h07;

  // Second instruction byte layout: address, bit index, form selector.
  localparam int ADDR_FIELD_MSB = 7;
  localparam int ADDR_FIELD_LSB = 4;
  localparam int BIT_FIELD_MSB  = 3;
  localparam int BIT_FIELD_LSB  = 1;
  localparam int SEL_FIELD_POS  = 0;

  // Address of the condition register.
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;

  // Bit positions of the flags inside the condition register byte.
  localparam int FLAG_C_POS = 7;
  localparam int FLAG_Z_POS = 6;
  localparam int FLAG_S_POS = 5;
  localparam int FLAG_V_POS = 4;
  localparam int FLAG_D_POS = 3;
  localparam int FLAG_H_POS = 2;

  // Instruction lengths in core clock cycles.
  localparam int CYC_SHORT = 4;
  localparam int CYC_LONG  = 6;
  // States visited by each instruction including the accept cycle in idle.
  localparam int PATH_SHORT = 4;
  localparam int PATH_LONG  = 6;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
  } bmeuFlags_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } bmeuInstr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } bmeuRegReq_t;

  typedef enum logic [1:0] {
    OP_COMPLEMENT = 2'b00,
    OP_CLEAR      = 2'b01,
    OP_SET        = 2'b10,
    OP_OR         = 2'b11
  } bmeuOp_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RD_SRC = 3'b001,
    ST_RD_DST = 3'b011,
    ST_CALC   = 3'b010,
    ST_HOLD   = 3'b110,
    ST_WRITE  = 3'b111
  } bmeuState_t;

endpackage

// *** hw/bmeu_bit_alu.sv ***
// Single-bit modify logic: complement, clear, set or OR one bit of a byte.
`timescale 1ns/10ps
module bmeu_bit_alu (
  input  wire bmeu_pkg::bmeuOp_t op,         // Operation to apply
  input  wire logic [7:0]        dstByte,    // Destination byte as read
  input  wire logic              srcBit,     // Other operand bit for the OR
  input  wire logic [2:0]        tgtIdx,     // Destination bit to modify
  output logic [7:0]             result,     // Byte to write back
  output logic                   resultZero  // Zero condition of the result
);
  import bmeu_pkg::*;

  wire logic [7:0] mask;
  wire logic       oldBit;
  wire logic       newBit;

  assign mask   = 8'h01 << tgtIdx;
  assign oldBit = dstByte[tgtIdx];

  assign newBit = (op == OP_COMPLEMENT) ? ~oldBit :      // RULE_01
                  (op == OP_CLEAR)      ? 1'b0 :         // RULE_03
                  (op == OP_SET)        ? 1'b1 :         // RULE_05
                                          (oldBit | srcBit); // RULE_10

  // Only the masked bit changes; the other seven pass through.
  assign result = (dstByte & ~mask) | (newBit ? mask : 8'h00); // RULE_01 RULE_03 RULE_05 RULE_10

  // The complement judges the whole byte, the OR judges the result bit.
  assign resultZero = (op == OP_OR) ? ~newBit : (result == 8'h00); // RULE_02 RULE_12

endmodule

// *** test/bmeu_props.sv ***
// Concurrent checks on the ports of the bit execution unit.
`timescale 1ns/10ps
module bmeu_props (
  input logic                  core_clk,   // Clock
  input logic                  resetn,     // Reset, active low
  input logic                  issueValid, // Offer
  input bmeu_pkg::bmeuInstr_t  issueInstr, // Bytes
  input logic                  issueReady, // Idle
  input logic                  opDone,     // Last cycle
  input logic                  illegalOp,  // Refused
  input logic [7:0]            workPtr,    // Bank pointer
  input bmeu_pkg::bmeuRegReq_t regReq,     // Request
  input logic [7:0]            regRdata,   // Read data
  input logic                  regLock,    // Held
  input logic                  flagLoad,   // Flag write
  input bmeu_pkg::bmeuFlags_t  flags       // Flags
);
  import bmeu_pkg::*;
  wire [7:0] op = issueInstr.opcode;
  wire [7:0] b2 = issueInstr.byte2;
  wire       legal = (op == OPC_BIT_COMPLEMENT && !b2[0]) || op == OPC_BIT_CLEAR_SET || op == OPC_BIT_OR;
  wire       acc = issueReady && issueValid && legal;
  wire [7:0] wa = {workPtr[7:4], b2[7:4]};
  // A write-back to the condition register overrides the flag update, so such cases are left out.
  wire       nof = !flagLoad && wa != FLAGS_ADDR && issueInstr.byte3 != FLAGS_ADDR;
  logic [7:0] waQ;
  logic [7:0] rdQ;
  logic [7:0] dstQ;
  logic [7:0] opQ;
  logic [7:0] mask;
  logic       selQ;
  wire [7:0] mod = opQ == OPC_BIT_COMPLEMENT ? rdQ ^ mask : selQ ? rdQ | mask : rdQ & ~mask;
  always_ff @(posedge core_clk) begin
    rdQ <= regRdata;
    waQ <= wa;
    if (acc) begin
      opQ <= op;
      selQ <= b2[0];
      dstQ <= wa;
      mask <= 8'h01 << b2[3:1];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_short; acc && op != OPC_BIT_OR |-> ##1 (!opDone && !issueReady)[*2] ##1 opDone ##1 issueReady; endproperty
  a_short: assert property (p_short) else $error("short length wrong");
  property p_long; acc && op == OPC_BIT_OR |-> ##1 (!opDone && !issueReady)[*4] ##1 opDone ##1 issueReady; endproperty
  a_long: assert property (p_long) else $error("long length wrong");
  property p_rdaddr; acc && op != OPC_BIT_OR |=> regReq.rd && regReq.addr == waQ; endproperty
  a_rdaddr: assert property (p_rdaddr) else $error("read address wrong");
  property p_wr; opDone && opQ != OPC_BIT_OR |-> regReq.wr && regReq.addr == dstQ && regReq.wdata == mod; endproperty
  a_wr: assert property (p_wr) else $error("write-back wrong");
  property p_keep; acc && op == OPC_BIT_CLEAR_SET && nof |=> $stable(flags)[*4]; endproperty
  a_keep: assert property (p_keep) else $error("flags changed");
  property p_cflg; acc && op == OPC_BIT_COMPLEMENT && nof |-> ##4 flags.z == ($past(regReq.wdata) == 8'h00)
    && !flags.s && flags.c == $past(flags.c, 4) && flags.d == $past(flags.d, 4) && flags.h == $past(flags.h, 4); endproperty
  a_cflg: assert property (p_cflg) else $error("complement flags wrong");
  property p_oflg; acc && op == OPC_BIT_OR && nof |-> ##6 !flags.s && flags.c == $past(flags.c, 6)
    && flags.d == $past(flags.d, 6) && flags.h == $past(flags.h, 6); endproperty
  a_oflg: assert property (p_oflg) else $error("or flags wrong");
  property p_bad; issueReady && issueValid && !legal |=> illegalOp && issueReady; endproperty
  a_bad: assert property (p_bad) else $error("bad opcode taken");
  property p_lock; (!issueReady || regReq.rd || regReq.wr) |-> regLock; endproperty
  a_lock: assert property (p_lock) else $error("lock dropped");
  property p_orrd; acc && op == OPC_BIT_OR |=> regReq.rd
    && regReq.addr == (selQ ? waQ : $past(issueInstr.byte3)); endproperty
  a_orrd: assert property (p_orrd) else $error("source read address wrong");
endmodule
bind bmeu_exec_unit bmeu_props u_props (.core_clk, .resetn, .issueValid, .issueInstr, .issueReady, .opDone,
  .illegalOp, .workPtr, .regReq, .regRdata, .regLock, .flagLoad, .flags);

// *** test/bmeu_regfile_model.sv ***
// Behavioural register file answering the unit's read and write strobes.
`timescale 1ns/10ps
module bmeu_regfile_model (
  input wire logic                  core_clk, // Clock
  input wire bmeu_pkg::bmeuRegReq_t regReq,   // Request
  output logic [7:0]                regRdata  // Data one cycle after rd
);
  import bmeu_pkg::*;
  logic [7:0] mem [256];
  initial regRdata = 8'h5A;
  // Between answers the data toggles, so a sample one cycle late sees the inverted answer.
  always @(posedge core_clk) begin
    regRdata <= regReq.rd ? mem[regReq.addr] : ~regRdata;
    if (regReq.wr) begin
      mem[regReq.addr] <= regReq.wdata;
    end
  end
endmodule

// *** test/tb_bit_manipulation_exec_unit.sv ***
// Self-checking bench for the bit execution unit with a register file model.
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_bit_manipulation_exec_unit;
  import bmeu_pkg::*;
  logic        core_clk;
  logic        resetn = 1'b0;
  logic        issueValid;
  bmeuInstr_t  issueInstr;
  logic        issueReady;
  logic        opDone;
  logic        illegalOp;
  logic [7:0]  workPtr;
  bmeuRegReq_t regReq;
  logic [7:0]  regRdata;
  logic        regLock;
  logic        flagLoad;
  logic [7:0]  flagLoadData;
  bmeuFlags_t  flags;
  logic [7:0]  flagsByte;
  int          n_errors = 0;
  int          tests_run = 0;
  bmeu_exec_unit dut_u (.core_clk, .resetn, .issueValid, .issueInstr, .issueReady, .opDone, .illegalOp,
    .workPtr, .regReq, .regRdata, .regLock, .flagLoad, .flagLoadData, .flags, .flagsByte);
  bmeu_regfile_model mdl_u (.core_clk, .regReq, .regRdata);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic end_sim;
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Called at a falling edge while idle; returns at the falling edge after write-back.
  task automatic run(input logic [7:0] o, input logic [7:0] b2, input logic [7:0] b3, input int cyc);
    int n;
    issueValid = 1'b1;
    issueInstr = '{o, b2, b3};
    @(negedge core_clk);
    issueValid = 1'b0;
    n = 1;
    while (opDone !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(n, cyc - 1)
    @(negedge core_clk);
  endtask
  task automatic setf(input logic [7:0] v);
    flagLoad = 1'b1;
    flagLoadData = v;
    @(negedge core_clk);
    flagLoad = 1'b0;
  endtask
  task automatic t_comp;
    mdl_u.mem[8'hC1] = 8'h07;
    mdl_u.mem[8'hC2] = 8'h01;
    setf(8'hEC);
    run(OPC_BIT_COMPLEMENT, 8'h12, 8'h00, CYC_SHORT);
    `CHK(mdl_u.mem[8'hC1], 8'h05)
    `CHK(flagsByte, 8'h8C)
    run(OPC_BIT_COMPLEMENT, 8'h20, 8'h00, CYC_SHORT);
    `CHK(mdl_u.mem[8'hC2], 8'h00)
    `CHK(flagsByte, 8'hCC)
  endtask
  task automatic t_clrset;
    mdl_u.mem[8'hC1] = 8'h07;
    mdl_u.mem[8'hC3] = 8'h07;
    setf(8'hEC);
    run(OPC_BIT_CLEAR_SET, 8'h12, 8'h00, CYC_SHORT);
    `CHK(mdl_u.mem[8'hC1], 8'h05)
    run(OPC_BIT_CLEAR_SET, 8'h37, 8'h00, CYC_SHORT);
    `CHK(mdl_u.mem[8'hC3], 8'h0F)
    run(OPC_BIT_CLEAR_SET, 8'h3F, 8'h00, CYC_SHORT);
    `CHK(mdl_u.mem[8'hC3], 8'h8F)
    `CHK(flagsByte, 8'hEC)
  endtask
  task automatic t_or;
    mdl_u.mem[8'hC1] = 8'h06;
    mdl_u.mem[8'h01] = 8'h03;
    setf(8'hFC);
    run(OPC_BIT_OR, 8'h14, 8'h01, CYC_LONG);
    `CHK(mdl_u.mem[8'hC1], 8'h06)
    `CHK(flagsByte, 8'hDC)
    mdl_u.mem[8'hC1] = 8'h07;
    run(OPC_BIT_OR, 8'h15, 8'h01, CYC_LONG);
    `CHK(mdl_u.mem[8'h01], 8'h07)
    `CHK(mdl_u.mem[8'hC1], 8'h07)
    `CHK(flagsByte, 8'h9C)
  endtask
  task automatic t_bad;
    logic [7:0] ops [3] = '{8'h57, 8'h00, 8'h67};
    for (int i = 0; i < 3; i++) begin
      issueValid = 1'b1;
      issueInstr = '{ops[i], 8'h13, 8'h01};
      @(negedge core_clk);
      issueValid = 1'b0;
      `CHK(illegalOp, 1'b1)
      `CHK(issueReady, 1'b1)
      @(negedge core_clk);
    end
    `CHK(mdl_u.mem[8'hC1], 8'h07)
  endtask
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
  initial begin
    issueValid = 1'b0;
    issueInstr = '0;
    workPtr = 8'hC0;
    flagLoad = 1'b0;
    flagLoadData = 8'h00;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    `CHK(flagsByte, FLAGS_RESET)
    `CHK(issueReady, 1'b1)
    t_comp();
    t_clrset();
    t_or();
    t_bad();
    end_sim();
  end
endmodule
